// ==== src/clkregs_params.svh ====
`ifndef CLKREGS_PARAMS_SVH
`define CLKREGS_PARAMS_SVH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define ADDR_INTERFACE_CONFIG   15'h000
`define ADDR_USER_SERIAL_CONFIG 15'h010
`define ADDR_CLOCK_CONTROL_ZERO 15'h029
`define ADDR_CLOCK_CONTROL_ONE  15'h02a
`define ADDR_EDGE_POS_LOW       15'h02c
`define ADDR_EDGE_POS_MID       15'h02d
`define ADDR_EDGE_POS_HIGH      15'h02e
`define ADDR_FS_A_LOW           15'h030
`define ADDR_FS_A_HIGH          15'h031
`define ADDR_FS_B_LOW           15'h032
`define ADDR_FS_B_HIGH          15'h033
`define ADDR_REF_BYPASS         15'h038
`define ADDR_TIMESTAMP_CTRL     15'h03b

// ****************************************************************
// Field positions.
// ****************************************************************
`define BIT_STREAM_DIRECTION    5
`define BIT_ADDRESS_HOLD        0
`define BIT_PROCESSOR_ENABLE    6
`define BIT_RECEIVER_ENABLE     5
`define BIT_STATUS_MAGNIFY      4
`define BIT_SAMPLE_CLOCK_PECL   2
`define BIT_SYSREF_PECL         1
`define BIT_POLARITY_FLIP       0
`define SYSREF_DELAY_AUTO       4'h0

// ****************************************************************
// Reset values.
// ****************************************************************
`define RST_INTERFACE_CONFIG    8'h20
`define RST_USER_SERIAL_CONFIG  8'h00
`define RST_CLOCK_CONTROL_ZERO  8'h00
`define RST_CLOCK_CONTROL_ONE   8'h20
`define RST_FULLSCALE           16'ha000
`define RST_REF_BYPASS          8'h00
`define RST_TIMESTAMP_CTRL      8'h00
`define RST_EDGE_POSITION       24'h000000

// ****************************************************************
// Serial frame geometry.
// ****************************************************************
`define HEADER_LAST_BIT         5'h0f
`define BYTE_LAST_BIT           5'h07

`endif

// ==== src/clkregs_pkg.sv ====
package clkregs_pkg;

	// Register address and data types.
	typedef logic [14:0] addr_t;
	typedef logic [7:0]  byte_t;
	typedef logic [23:0] position_t;

	// Phase of a serial frame.
	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_HEADER = 2'b01,
		PH_DATA   = 2'b10
	} phase_e;

endpackage

// ==== src/serial_port_engine.sv ====
`timescale 1ns/100ps
`include "clkregs_params.svh"

module serial_port_engine
	import clkregs_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic            clk_i,
	input  wire logic            rst_n_i,
	input  wire logic            ce_i,
	// Serial pins.
	input  wire logic            sclk_i,
	input  wire logic            scs_n_i,
	input  wire logic            sdi_i,
	output logic                 sdo_o,
	output logic                 sdo_oe_o,
	// Frame events towards the register file.
	output logic                 hdr_done_o,
	output logic                 is_read_o,
	output clkregs_pkg::addr_t   hdr_addr_o,
	output logic                 byte_done_o,
	output clkregs_pkg::byte_t   rx_byte_o,
	input  wire clkregs_pkg::byte_t tx_byte_i
);

	import clkregs_pkg::*;

	phase_e       phase_r;
	logic         sclk_q_r;
	logic [4:0]   cnt_r;
	logic [15:0]  rx_sr_r;
	logic [7:0]   tx_sr_r;
	logic         is_read_r;
	logic         rise;
	logic         fall;

	// Edges of the serial clock seen against the system clock.
	assign rise = sclk_i & ~sclk_q_r;
	assign fall = ~sclk_i & sclk_q_r;

	// Serial clock history for edge detection.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sclk_q_r <= 1'b0;
		end else if (ce_i) begin
			sclk_q_r <= sclk_i;
		end
	end

	// Frame phase, bit counter and receive shifter.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			phase_r     <= PH_IDLE;
			cnt_r       <= 5'h00;
			rx_sr_r     <= 16'h0000;
			is_read_r   <= 1'b0;
			hdr_done_o  <= 1'b0;
			byte_done_o <= 1'b0;
			hdr_addr_o  <= 15'h0000;
			rx_byte_o   <= 8'h00;
		end else if (ce_i) begin
			hdr_done_o  <= 1'b0;
			byte_done_o <= 1'b0;
			if (scs_n_i) begin
				phase_r <= PH_IDLE;
				cnt_r   <= 5'h00;
			end else if (rise) begin
				rx_sr_r <= {rx_sr_r[14:0], sdi_i};
				case (phase_r)
					PH_IDLE, PH_HEADER: begin
						phase_r <= PH_HEADER;
						if (cnt_r == `HEADER_LAST_BIT) begin
							phase_r    <= PH_DATA;
							cnt_r      <= 5'h00;
							hdr_done_o <= 1'b1;
							is_read_r  <= rx_sr_r[14];
							hdr_addr_o <= {rx_sr_r[13:0], sdi_i};
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
					PH_DATA: begin
						if (cnt_r == `BYTE_LAST_BIT) begin
							cnt_r       <= 5'h00;
							byte_done_o <= 1'b1;
							rx_byte_o   <= {rx_sr_r[6:0], sdi_i};
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
					default: begin
						phase_r <= PH_IDLE;
					end
				endcase
			end
		end
	end

	// Transmit shifter: loads a byte at each byte boundary, shifts on falling edges.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tx_sr_r <= 8'h00;
		end else if (ce_i && fall && phase_r == PH_DATA) begin
			if (cnt_r == 5'h00) begin
				tx_sr_r <= tx_byte_i;
			end else begin
				tx_sr_r <= {tx_sr_r[6:0], 1'b0};
			end
		end
	end

	// Output drive only during the data phase of a read.
	assign is_read_o = is_read_r;
	assign sdo_o     = tx_sr_r[7];
	assign sdo_oe_o  = ~scs_n_i & is_read_r & (phase_r == PH_DATA);

endmodule

// ==== src/spi_clock_sysref_control_regs.sv ====
`timescale 1ns/100ps
`include "clkregs_params.svh"

// Notes on behaviour
// [R1] With address hold clear, streaming moves the address in the direction set by the direction bit.
// [R2] With address hold set, the address stays fixed through the whole streaming transfer.
// [R3] Without hold, the address decrements per byte when direction is zero and increments when one.
// [R4] SYSREF events are processed only while the processor enable bit is set.
// [R5] The host enables the SYSREF receiver no later than it enables the processor.
// [R6] The receiver enable bit turns the SYSREF receiver on, and it is off after reset.
// [R7] The magnify bit selects the zoomed resolution that the edge-position status reports.
// [R8] The four-bit delay-select field chooses the SYSREF capture delay applied.
// [R9] A delay select of zero means automatic SYSREF timing calibration.
// [R10] Software reads the edge position and then programs a suitable manual delay.
// [R11] The sample clock PECL bit switches the device clock input into low-voltage PECL mode.
// [R12] The SYSREF PECL bit switches the SYSREF input into low-voltage PECL mode.
// [R13] The polarity flip bit inverts SYSREF before it is used for alignment.
// [R14] A read-only 24-bit status shows the SYSREF edge position against the device clock.
// [R15] The edge-position status spans three consecutive byte addresses and has no defined reset value; the code resets it to zero.
// [R16] Clock control register zero resets to all zeros.
// [R17] Writes to the edge-position status bytes are ignored.

module spi_clock_sysref_control_regs
	import clkregs_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic                    MCLK_I,
	input  wire logic                    RESET_N_I,
	input  wire logic                    CE_I,
	// Four-wire serial port.
	input  wire logic                    SCLK_I,
	input  wire logic                    SCS_N_I,
	input  wire logic                    SDI_I,
	output logic                         SDO_O,
	output logic                         SDO_OE_O,
	// SYSREF input and edge measurements.
	input  wire logic                    SYSREF_I,
	input  wire clkregs_pkg::position_t  POS_COARSE_I,
	input  wire clkregs_pkg::position_t  POS_MAGNIFIED_I,
	// SYSREF controls.
	output logic                         SYSREF_RECEIVER_EN_O,
	output logic                         SYSREF_EVENT_O,
	output logic [3:0]                   SYSREF_DELAY_SEL_O,
	output logic                         SYSREF_AUTO_CAL_O,
	output logic                         SYSREF_PECL_O,
	// Other analog controls.
	output logic                         SAMPLE_CLOCK_PECL_O,
	output logic [15:0]                  INPUT_A_FS_O,
	output logic [15:0]                  INPUT_B_FS_O,
	output logic                         REF_BYPASS_O,
	output logic [7:0]                   TIMESTAMP_CTRL_O
);

	import clkregs_pkg::*;

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic       hdr_done;
	logic       is_read;
	addr_t      hdr_addr;
	logic       byte_done;
	byte_t      rx_byte;
	byte_t      rd_data;
	addr_t      cur_addr_r;
	byte_t      iface_cfg_r;
	byte_t      user_cfg_r;
	byte_t      clk0_r;
	byte_t      clk1_r;
	position_t  edge_pos_r;
	logic [15:0] fs_a_r;
	logic [15:0] fs_b_r;
	byte_t      bypass_r;
	byte_t      tstamp_r;
	logic       sysref_q_r;
	logic       sysref_prev_r;
	logic       sysref_lvl;
	logic       sysref_rise;
	logic       wr;

	// ****************************************************************
	// Serial port.
	// ****************************************************************
	serial_port_engine u_engine (
		.clk_i       (MCLK_I),
		.rst_n_i     (RESET_N_I),
		.ce_i        (CE_I),
		.sclk_i      (SCLK_I),
		.scs_n_i     (SCS_N_I),
		.sdi_i       (SDI_I),
		.sdo_o       (SDO_O),
		.sdo_oe_o    (SDO_OE_O),
		.hdr_done_o  (hdr_done),
		.is_read_o   (is_read),
		.hdr_addr_o  (hdr_addr),
		.byte_done_o (byte_done),
		.rx_byte_o   (rx_byte),
		.tx_byte_i   (rd_data)
	);

	// A completed data byte of a write frame.
	// Read frames never write, so whatever the host shifts in then is harmless.
	assign wr = byte_done & ~is_read;

	// Streaming address: loaded from the header, then held or stepped per byte.
	// A header and a byte strobe never fall in one cycle, so the header has no rival.
	always_ff @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			cur_addr_r <= 15'h0000;
		end else if (CE_I) begin
			if (hdr_done) begin
				cur_addr_r <= hdr_addr;
			end else if (byte_done) begin
				// [R2] address stays fixed
				if (user_cfg_r[`BIT_ADDRESS_HOLD]) begin
					cur_addr_r <= cur_addr_r;
				// [R1] [R3] step by direction
				end else if (iface_cfg_r[`BIT_STREAM_DIRECTION]) begin
					cur_addr_r <= cur_addr_r + 15'h0001;
				end else begin
					cur_addr_r <= cur_addr_r - 15'h0001;
				end
			end
		end
	end

	// ****************************************************************
	// Writable registers.
	// ****************************************************************
	// Each written byte lands in the register that the current address selects; the two serial config registers keep only one bit, status bytes none.
	always_ff @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			iface_cfg_r <= `RST_INTERFACE_CONFIG;
			user_cfg_r  <= `RST_USER_SERIAL_CONFIG;
			// [R16] control zero cleared
			clk0_r      <= `RST_CLOCK_CONTROL_ZERO;
			clk1_r      <= `RST_CLOCK_CONTROL_ONE;
			fs_a_r      <= `RST_FULLSCALE;
			fs_b_r      <= `RST_FULLSCALE;
			bypass_r    <= `RST_REF_BYPASS;
			tstamp_r    <= `RST_TIMESTAMP_CTRL;
		end else if (CE_I && wr) begin
			case (cur_addr_r)
				`ADDR_INTERFACE_CONFIG:   iface_cfg_r[`BIT_STREAM_DIRECTION] <= rx_byte[`BIT_STREAM_DIRECTION];
				`ADDR_USER_SERIAL_CONFIG: user_cfg_r[`BIT_ADDRESS_HOLD] <= rx_byte[`BIT_ADDRESS_HOLD];
				`ADDR_CLOCK_CONTROL_ZERO: clk0_r <= rx_byte;
				`ADDR_CLOCK_CONTROL_ONE:  clk1_r <= rx_byte;
				`ADDR_FS_A_LOW:           fs_a_r[7:0] <= rx_byte;
				`ADDR_FS_A_HIGH:          fs_a_r[15:8] <= rx_byte;
				`ADDR_FS_B_LOW:           fs_b_r[7:0] <= rx_byte;
				`ADDR_FS_B_HIGH:          fs_b_r[15:8] <= rx_byte;
				`ADDR_REF_BYPASS:         bypass_r <= rx_byte;
				`ADDR_TIMESTAMP_CTRL:     tstamp_r <= rx_byte;
				// [R17] status bytes ignored
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// Read data.
	// ****************************************************************
	// Byte returned for the current address; unmapped addresses read zero.
	always_comb begin
		case (cur_addr_r)
			`ADDR_INTERFACE_CONFIG:   rd_data = iface_cfg_r;
			`ADDR_USER_SERIAL_CONFIG: rd_data = user_cfg_r;
			`ADDR_CLOCK_CONTROL_ZERO: rd_data = clk0_r;
			`ADDR_CLOCK_CONTROL_ONE:  rd_data = clk1_r;
			// [R14] [R15] three status bytes
			`ADDR_EDGE_POS_LOW:       rd_data = edge_pos_r[7:0];
			`ADDR_EDGE_POS_MID:       rd_data = edge_pos_r[15:8];
			`ADDR_EDGE_POS_HIGH:      rd_data = edge_pos_r[23:16];
			`ADDR_FS_A_LOW:           rd_data = fs_a_r[7:0];
			`ADDR_FS_A_HIGH:          rd_data = fs_a_r[15:8];
			`ADDR_FS_B_LOW:           rd_data = fs_b_r[7:0];
			`ADDR_FS_B_HIGH:          rd_data = fs_b_r[15:8];
			`ADDR_REF_BYPASS:         rd_data = bypass_r;
			`ADDR_TIMESTAMP_CTRL:     rd_data = tstamp_r;
			default:                  rd_data = 8'h00;
		endcase
	end

	// ****************************************************************
	// SYSREF path.
	// ****************************************************************
	// [R13] [R6] flip then gate
	assign sysref_lvl = (SYSREF_I ^ clk1_r[`BIT_POLARITY_FLIP]) & clk0_r[`BIT_RECEIVER_ENABLE];
	assign sysref_rise = sysref_q_r & ~sysref_prev_r;

	// Received SYSREF level and its history.
	// Both flops reset low, the idle level, so no false edge follows reset.
	always_ff @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			sysref_q_r    <= 1'b0;
			sysref_prev_r <= 1'b0;
		end else if (CE_I) begin
			sysref_q_r    <= sysref_lvl;
			sysref_prev_r <= sysref_q_r;
		end
	end

	// Event pulse and edge-position capture while the processor is enabled.
	always_ff @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			SYSREF_EVENT_O <= 1'b0;
			edge_pos_r     <= `RST_EDGE_POSITION;
		end else if (CE_I) begin
			// [R4] processor gates events
			SYSREF_EVENT_O <= sysref_rise & clk0_r[`BIT_PROCESSOR_ENABLE];
			if (sysref_rise && clk0_r[`BIT_PROCESSOR_ENABLE]) begin
				// [R7] magnified status select
				edge_pos_r <= clk0_r[`BIT_STATUS_MAGNIFY] ? POS_MAGNIFIED_I : POS_COARSE_I;
			end
		end
	end

	// ****************************************************************
	// Control outputs.
	// ****************************************************************
	// Register fields driven straight to the analog controls, except the auto-calibration flag, which is decoded from the delay select.
	assign SYSREF_RECEIVER_EN_O = clk0_r[`BIT_RECEIVER_ENABLE];
	// [R8] delay select out
	assign SYSREF_DELAY_SEL_O   = clk0_r[3:0];
	// [R9] zero means calibration
	assign SYSREF_AUTO_CAL_O    = (clk0_r[3:0] == `SYSREF_DELAY_AUTO);
	// [R11] [R12] input modes
	assign SAMPLE_CLOCK_PECL_O  = clk1_r[`BIT_SAMPLE_CLOCK_PECL];
	assign SYSREF_PECL_O        = clk1_r[`BIT_SYSREF_PECL];
	assign INPUT_A_FS_O         = fs_a_r;
	assign INPUT_B_FS_O         = fs_b_r;
	assign REF_BYPASS_O         = bypass_r[0];
	assign TIMESTAMP_CTRL_O     = tstamp_r;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);

	// Streaming address: held, down or up after each byte.
	AST_HOLD_ADDR: assert property (CE_I && byte_done && !hdr_done && user_cfg_r[0] // [R2]
		|=> cur_addr_r == $past(cur_addr_r)) else $error("Held address moved.");
	AST_ADDR_DOWN: assert property (CE_I && byte_done && !user_cfg_r[0] && !iface_cfg_r[5] // [R3]
		|=> cur_addr_r == $past(cur_addr_r) - 15'h0001) else $error("Address did not decrement.");
	AST_ADDR_UP: assert property (CE_I && byte_done && !user_cfg_r[0] && iface_cfg_r[5] // [R1]
		|=> cur_addr_r == $past(cur_addr_r) + 15'h0001) else $error("Address did not increment.");

	// SYSREF path: gate, receiver, polarity and capture.
	AST_EVENT_GATED: assert property (SYSREF_EVENT_O |-> $past(clk0_r[6])) // [R4]
		else $error("SYSREF event while processor disabled.");
	AST_RECV_OFF: assert property (CE_I && !clk0_r[5] |=> !sysref_q_r) // [R6]
		else $error("SYSREF passed with receiver off.");
	AST_FLIP: assert property (CE_I && clk0_r[5] && clk1_r[0] |=> sysref_q_r == !$past(SYSREF_I)) // [R13]
		else $error("SYSREF polarity not inverted.");
	AST_MAGNIFY: assert property (CE_I && sysref_rise && clk0_r[6] && clk0_r[4] // [R7]
		|=> edge_pos_r == $past(POS_MAGNIFIED_I)) else $error("Magnified position not captured.");

	// Writes and the read-only status.
	AST_DELAY_WRITE: assert property (CE_I && wr && cur_addr_r == 15'h0029 // [R8]
		|=> SYSREF_DELAY_SEL_O == $past(rx_byte[3:0])) else $error("Delay select not written.");
	AST_POS_RO: assert property (CE_I && wr && cur_addr_r >= 15'h002c && cur_addr_r <= 15'h002e // [R17]
		&& !(sysref_rise && clk0_r[6]) |=> $stable(edge_pos_r)) else $error("Status byte was written.");
	AST_CLK0_RESET: assert property (@(posedge MCLK_I) disable iff (1'b0) !RESET_N_I |=> clk0_r == 8'h00) // [R16]
		else $error("Clock control zero not cleared by reset.");

	// Register writes reach the controls.
	AST_DIR_WRITE: assert property (CE_I && wr && cur_addr_r == 15'h0000 // [R3]
		|=> iface_cfg_r[5] == $past(rx_byte[5])) else $error("Direction bit not written.");
	AST_HOLD_WRITE: assert property (CE_I && wr && cur_addr_r == 15'h0010 // [R2]
		|=> user_cfg_r[0] == $past(rx_byte[0])) else $error("Hold bit not written.");
	AST_RECV_WRITE: assert property (CE_I && wr && cur_addr_r == 15'h0029 // [R6]
		|=> SYSREF_RECEIVER_EN_O == $past(rx_byte[5])) else $error("Receiver enable not written.");
	AST_AUTO_CAL: assert property (CE_I && wr && cur_addr_r == 15'h0029 // [R9]
		|=> SYSREF_AUTO_CAL_O == ($past(rx_byte[3:0]) == 4'h0)) else $error("Calibration select wrong.");
	AST_PECL_WRITE: assert property (CE_I && wr && cur_addr_r == 15'h002a // [R11]
		|=> SAMPLE_CLOCK_PECL_O == $past(rx_byte[2])) else $error("Clock input mode not written.");
	AST_SREF_PECL: assert property (CE_I && wr && cur_addr_r == 15'h002a // [R12]
		|=> SYSREF_PECL_O == $past(rx_byte[1])) else $error("SYSREF input mode not written.");

	// SYSREF event shape and capture.
	AST_NO_EVENT: assert property (CE_I && !clk0_r[6] |=> !SYSREF_EVENT_O) // [R4]
		else $error("Event raised with processor off.");
	AST_ONE_SHOT: assert property (CE_I && SYSREF_EVENT_O |=> !SYSREF_EVENT_O) // [R4]
		else $error("Event longer than one cycle.");
	AST_COARSE: assert property (CE_I && sysref_rise && clk0_r[6] && !clk0_r[4] // [R7]
		|=> edge_pos_r == $past(POS_COARSE_I)) else $error("Coarse position not captured.");
	AST_NO_FLIP: assert property (CE_I && clk0_r[5] && !clk1_r[0] |=> sysref_q_r == $past(SYSREF_I)) // [R13]
		else $error("Sysref_polarity_flip with flip clear.");

	// A low clock enable must freeze the address, the controls and the status.
	// Frozen pulses resume exactly where they stopped once it rises.
	AST_FREEZE: assert property (!CE_I |=> $stable(cur_addr_r) && $stable(clk0_r) && $stable(edge_pos_r))
		else $error("State moved while clock enable was low.");

	// Main scenarios worth seeing.
	COV_EVENT: cover property (SYSREF_EVENT_O);
	COV_HOLD_STREAM: cover property (byte_done && user_cfg_r[0] ##[1:200] byte_done);
	COV_READ_FRAME: cover property (SDO_OE_O ##1 byte_done);
	COV_MANUAL_DELAY: cover property (!SYSREF_AUTO_CAL_O);
	COV_FREEZE: cover property (!CE_I ##1 CE_I);

endmodule

// ==== testbench/spi_clock_sysref_control_regs_tb.sv ====
`timescale 1ns/100ps

module spi_clock_sysref_control_regs_tb;
	import clkregs_pkg::*;

	// ****************************************************************
	// Signals.
	// ****************************************************************
	logic                MCLK_I = 1'b0;
	logic                RESET_N_I = 1'b0;
	logic                CE_I = 1'b1;
	logic                SCLK_I, SCS_N_I, SDI_I, SDO_O, SDO_OE_O;
	logic                SYSREF_I = 1'b0;
	position_t           POS_COARSE_I = 24'h000000;
	position_t           POS_MAGNIFIED_I = 24'h000000;
	logic                SYSREF_RECEIVER_EN_O, SYSREF_EVENT_O, SYSREF_AUTO_CAL_O, SYSREF_PECL_O;
	logic                SAMPLE_CLOCK_PECL_O, REF_BYPASS_O, rd_valid;
	logic [3:0]          SYSREF_DELAY_SEL_O;
	logic [15:0]         INPUT_A_FS_O, INPUT_B_FS_O;
	logic [7:0]          TIMESTAMP_CTRL_O, rd_byte, v;
	logic [31:0]         seed = 32'h32f639b6;
	logic [7:0]          rd_q[$];
	logic                ev_q[$];
	int                  n_mismatch = 0;
	int                  check_count = 0;

	// Clock of 5 ns period.
	always #2.5 MCLK_I = ~MCLK_I;

	spi_clock_sysref_control_regs dut (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .SCLK_I(SCLK_I),
		.SCS_N_I(SCS_N_I), .SDI_I(SDI_I), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O), .SYSREF_I(SYSREF_I),
		.POS_COARSE_I(POS_COARSE_I), .POS_MAGNIFIED_I(POS_MAGNIFIED_I),
		.SYSREF_RECEIVER_EN_O(SYSREF_RECEIVER_EN_O), .SYSREF_EVENT_O(SYSREF_EVENT_O),
		.SYSREF_DELAY_SEL_O(SYSREF_DELAY_SEL_O), .SYSREF_AUTO_CAL_O(SYSREF_AUTO_CAL_O),
		.SYSREF_PECL_O(SYSREF_PECL_O), .SAMPLE_CLOCK_PECL_O(SAMPLE_CLOCK_PECL_O), .INPUT_A_FS_O(INPUT_A_FS_O),
		.INPUT_B_FS_O(INPUT_B_FS_O), .REF_BYPASS_O(REF_BYPASS_O), .TIMESTAMP_CTRL_O(TIMESTAMP_CTRL_O));

	spi_host_model host (.clk_i(MCLK_I), .sdo_i(SDO_O), .sclk_o(SCLK_I), .scs_n_o(SCS_N_I), .sdi_o(SDI_I),
		.rd_valid_o(rd_valid), .rd_byte_o(rd_byte));

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	// Next value of the pseudo-random sequence.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Compare one bit.
	task automatic cmp_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
		end
	endtask

	// Compare one byte.
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: byte got %h expected %h", $time, got, exp);
		end
	endtask

	// Verdict and end of run.
	task automatic finish_test;
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Frame tasks; reads note their expected bytes first.
	task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
		host.run(1'b0, a, n, d);
	endtask

	task automatic rd(input logic [14:0] a, input int n, input logic [31:0] e);
		for (int k = 0; k < n; k++) begin
			rd_q.push_back(e[8*k+:8]);
		end
		seed = lfsr(seed);
		host.run(1'b1, a, n, seed);
	endtask

	// Drive the SYSREF level and let any event settle.
	task automatic sref(input logic lvl);
		@(posedge MCLK_I);
		SYSREF_I <= lvl;
		repeat (8) @(posedge MCLK_I);
	endtask

	// ****************************************************************
	// Output watcher: read bytes and SYSREF events against the notes.
	// ****************************************************************
	always @(posedge MCLK_I) begin
		if (rd_valid === 1'b1) begin
			cmp_bit(SDO_OE_O, 1'b1);
			if (rd_q.size() == 0) cmp_bit(1'b0, 1'b1);
			else cmp_byte(rd_byte, rd_q.pop_front());
		end
		if (SYSREF_EVENT_O === 1'b1) begin
			if (ev_q.size() == 0) cmp_bit(1'b1, 1'b0);
			else cmp_bit(SYSREF_EVENT_O, ev_q.pop_front());
		end
	end

	// Watchdog against a hang.
	initial begin
		repeat (100000) @(posedge MCLK_I);
		n_mismatch++;
		finish_test();
	end

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		repeat (4) @(posedge MCLK_I);
		RESET_N_I <= 1'b1;
		POS_COARSE_I <= seed[23:0];
		POS_MAGNIFIED_I <= ~seed[23:0];
		@(posedge MCLK_I);
		cmp_bit(SYSREF_RECEIVER_EN_O, 1'b0);
		cmp_bit(SYSREF_AUTO_CAL_O, 1'b1);
		cmp_byte(INPUT_A_FS_O[15:8], 8'ha0);
		cmp_byte(INPUT_B_FS_O[7:0], 8'h00);
		cmp_bit(REF_BYPASS_O, 1'b0);
		cmp_byte(TIMESTAMP_CTRL_O, 8'h00);
		rd(15'h010, 1, 8'h00);
		rd(15'h029, 1, 8'h00);
		rd(15'h02a, 1, 8'h20);
		wr(15'h032, 2, 16'h5a3c);
		cmp_byte(INPUT_B_FS_O[15:8], 8'h5a);
		cmp_byte(INPUT_B_FS_O[7:0], 8'h3c);
		wr(15'h038, 1, 8'h01);
		cmp_bit(REF_BYPASS_O, 1'b1);
		wr(15'h03b, 1, 8'h03);
		cmp_byte(TIMESTAMP_CTRL_O, 8'h03);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			v = seed[7:0];
			v[6] = 1'b0;
			if (i == 0) v[3:0] = 4'h0;
			wr(15'h029, 1, v);
			cmp_bit(SYSREF_RECEIVER_EN_O, v[5]);
			cmp_byte({4'h0, SYSREF_DELAY_SEL_O}, {4'h0, v[3:0]});
			cmp_bit(SYSREF_AUTO_CAL_O, v[3:0] == 4'h0);
			rd(15'h029, 1, v);
		end
		seed = lfsr(seed);
		wr(15'h02a, 1, seed[7:0]);
		cmp_bit(SAMPLE_CLOCK_PECL_O, seed[2]);
		cmp_bit(SYSREF_PECL_O, seed[1]);
		rd(15'h02a, 1, seed[7:0]);
		wr(15'h029, 2, 16'h2413);
		rd(15'h029, 2, 16'h2413);
		wr(15'h000, 1, 8'h00);
		wr(15'h02a, 2, 16'h0506);
		rd(15'h02a, 2, 16'h0506);
		wr(15'h000, 1, 8'h20);
		wr(15'h010, 1, 8'h01);
		wr(15'h029, 2, 16'h0a07);
		rd(15'h029, 2, 16'h0a0a);
		wr(15'h010, 1, 8'h00);
		rd(15'h02a, 1, 8'h06);
		wr(15'h02a, 1, 8'h20);
		// Receiver is enabled before the processor.
		wr(15'h029, 1, 8'h20);
		wr(15'h029, 1, 8'h60);
		ev_q.push_back(1'b1);
		sref(1'b1);
		sref(1'b0);
		rd(15'h02c, 3, POS_COARSE_I);
		wr(15'h029, 1, 8'h70);
		ev_q.push_back(1'b1);
		sref(1'b1);
		sref(1'b0);
		rd(15'h02c, 3, POS_MAGNIFIED_I);
		seed = lfsr(seed);
		wr(15'h02c, 3, seed);
		rd(15'h02c, 3, POS_MAGNIFIED_I);
		ev_q.push_back(1'b1);
		wr(15'h02a, 1, 8'h21);
		repeat (8) @(posedge MCLK_I);
		sref(1'b1);
		ev_q.push_back(1'b1);
		sref(1'b0);
		wr(15'h029, 1, 8'h30);
		POS_MAGNIFIED_I <= seed[23:0];
		sref(1'b1);
		sref(1'b0);
		rd(15'h02c, 3, ~POS_COARSE_I);
		// Software picks a manual delay from the position just read.
		wr(15'h029, 1, {4'h6, POS_COARSE_I[3:0] ^ 4'hf});
		cmp_byte({4'h0, SYSREF_DELAY_SEL_O}, {4'h0, ~POS_COARSE_I[3:0]});
		repeat (8) @(posedge MCLK_I);
		// Clock enable low freezes the SYSREF history, so this flipped pulse makes no event.
		CE_I <= 1'b0;
		sref(1'b1);
		sref(1'b0);
		CE_I <= 1'b1;
		repeat (8) @(posedge MCLK_I);
		cmp_bit(rd_q.size() == 0, 1'b1);
		cmp_bit(ev_q.size() == 0, 1'b1);
		finish_test();
	end
endmodule

// ==== testbench/spi_host_model.sv ====
`timescale 1ns/100ps

// ****************************************************************
// Serial host that frames reads and writes for the register bank.
// ****************************************************************
module spi_host_model (
	// Clock.
	input  wire logic        clk_i,
	// Serial pins.
	input  wire logic        sdo_i,
	output logic             sclk_o,
	output logic             scs_n_o,
	output logic             sdi_o,
	// Read data towards the bench.
	output logic             rd_valid_o,
	output logic [7:0]       rd_byte_o
);
	// Idle levels at time zero: clock low, not selected.
	initial begin
		sclk_o     = 1'b0;
		scs_n_o    = 1'b1;
		sdi_o      = 1'b0;
		rd_valid_o = 1'b0;
		rd_byte_o  = 8'h00;
	end

	// One serial bit: four cycles low with data set up, then four high.
	task automatic bit_cyc(input logic b, output logic s);
		sclk_o <= 1'b0;
		sdi_o  <= b;
		repeat (4) @(posedge clk_i);
		s = sdo_i;
		sclk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask

	// Whole frame: header, then n bytes, low byte of wd first.
	task automatic run(input logic rd, input logic [14:0] a, input int n, input logic [31:0] wd);
		logic [15:0] hdr;
		logic [7:0]  b;
		logic        s;
		hdr = {rd, a};
		scs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(hdr[i], s);
		end
		for (int k = 0; k < n; k++) begin
			for (int j = 7; j >= 0; j--) begin
				bit_cyc(wd[8*k+j], s);
				b[j] = s;
			end
			if (rd) begin
				rd_byte_o  <= b;
				rd_valid_o <= 1'b1;
				@(posedge clk_i);
				rd_valid_o <= 1'b0;
			end
		end
		@(posedge clk_i);
		sclk_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		// Released data line toggles so a stale level is never mistaken for data.
		scs_n_o <= 1'b1;
		sdi_o   <= ~sdi_o;
		repeat (3) @(posedge clk_i);
	endtask
endmodule
